// >>> hw/sfrs_sequencer.v
// Purpose: cold and warm reset sequencing for a serial flash device
// Assumes: supply monitor, reset, chip select and serial clock arrive as pins
// Notes:   serial clock is sampled by clk and its rising edges are found here
`include "sfrs_regs.vh"

module sfrs_sequencer #(
   parameter CNT_W = 13
) (
   input  wire clk,
   input  wire rst,
   input  wire supplyOk,
   input  wire porFault,
   input  wire resetN,
   input  wire csN,
   input  wire sck,
   input  wire coreIoOeN,
   output reg  ready_q,
   output reg  selected_q,
   output reg  sckRise_q,
   output reg  opAbort_q,
   output reg  regRestore_q,
   output reg  ioOeN_q,
   output reg  porDone_q
);
   // derived cycle counts: longest rounds down, least rounds up
   localparam integer     PU_INT  = (`SFRS_POWERUP_DELAY_US * `SFRS_CLK_KHZ) / 1000;
   localparam integer     RPH_INT = (`SFRS_RECOVERY_TIME_US * `SFRS_CLK_KHZ + 999) / 1000;
   localparam integer     RP_INT  = (`SFRS_PULSE_WIDTH_NS * `SFRS_CLK_KHZ + 999999) / 1000000;
   localparam integer     RH_INT  = (`SFRS_HOLD_TIME_NS * `SFRS_CLK_KHZ + 999999) / 1000000;
   // counts cut to the counter width on purpose
   localparam [CNT_W-1:0] PU_CYC  = PU_INT[CNT_W-1:0];
   localparam [CNT_W-1:0] RPH_CYC = RPH_INT[CNT_W-1:0];
   localparam [CNT_W-1:0] RP_CYC  = RP_INT[CNT_W-1:0];
   localparam [CNT_W-1:0] RH_CYC  = RH_INT[CNT_W-1:0];

   wire [4:0] pinSync;
   wire       vccS;
   wire       faultS;
   wire       resetNS;
   wire       csNS;
   wire       sckS;

   reg  [2:0]       state_q;
   reg  [2:0]       state_d;
   reg  [CNT_W-1:0] cnt_q;
   reg  [CNT_W-1:0] cnt_d;
   reg              porBad_q;
   reg              porBad_d;
   reg              csHighSeen_q;
   reg              sckPrev_q;
   reg              abort_d;
   reg              restore_d;

   // all pins pass two flops; reset and chip select idle high
   sfrs_sync #(
      .WIDTH (5),
      .INIT  (5'h0C)
   ) u_sync (
      .clk     (clk),
      .rst     (rst),
      .pinIn   ({sck, csN, resetN, porFault, supplyOk}),
      .syncOut (pinSync)
   );
   assign vccS    = pinSync[0];
   assign faultS  = pinSync[1];
   assign resetNS = pinSync[2];
   assign csNS    = pinSync[3];
   assign sckS    = pinSync[4];

   // sequencer next state
   always @* begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      porBad_d  = porBad_q;
      abort_d   = 1'b0;
      restore_d = 1'b0;
      case (state_q)
         `SFRS_ST_OFF: begin
            cnt_d = {CNT_W{1'b0}};
            if (vccS) begin
               state_d   = `SFRS_ST_POR;
               porBad_d  = 1'b0;
               restore_d = 1'b1;
            end
         end
         `SFRS_ST_POR: begin
            // reset pin looked at only when the power-up delay ends
            if (faultS)
               porBad_d = 1'b1;
            if (cnt_q >= PU_CYC - 1'b1) begin
               cnt_d   = {CNT_W{1'b0}};
               state_d = resetNS ? `SFRS_ST_READY : `SFRS_ST_HELD;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         `SFRS_ST_HELD: begin
            // stays in reset until pin high for hold time
            if (!resetNS)
               cnt_d = {CNT_W{1'b0}};
            else if (cnt_q >= RH_CYC - 1'b1)
               state_d = `SFRS_ST_READY;
            else
               cnt_d = cnt_q + 1'b1;
         end
         `SFRS_ST_READY: begin
            cnt_d = {CNT_W{1'b0}};
            if (!resetNS) begin
               // first low sample already counts toward the pulse width
               state_d = `SFRS_ST_LOW;
               cnt_d   = {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
         `SFRS_ST_LOW: begin
            // qualify the pulse width before acting
            if (!resetNS) begin
               cnt_d = cnt_q + 1'b1;
               if (cnt_q >= RP_CYC - 1'b1) begin
                  abort_d   = 1'b1;
                  restore_d = 1'b1;
                  if (porBad_q) begin
                     state_d  = `SFRS_ST_POR;
                     porBad_d = 1'b0;
                     cnt_d    = {CNT_W{1'b0}};
                  end else begin
                     state_d = `SFRS_ST_RECOV;
                  end
               end
            end else begin
               state_d = `SFRS_ST_READY;
            end
         end
         `SFRS_ST_RECOV: begin
            // recovery counts from reset low; also waits for release
            if (cnt_q < RPH_CYC)
               cnt_d = cnt_q + 1'b1;
            else if (resetNS)
               state_d = `SFRS_ST_READY;
         end
         default: begin
            state_d = `SFRS_ST_OFF;
            cnt_d   = {CNT_W{1'b0}};
         end
      endcase
      if (!vccS && state_q != `SFRS_ST_OFF) begin
         state_d = `SFRS_ST_OFF;
         abort_d = 1'b1;
      end
   end

   // state and counter registers
   always @(posedge clk) begin
      if (rst) begin
         state_q  <= `SFRS_ST_OFF;
         cnt_q    <= {CNT_W{1'b0}};
         porBad_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         porBad_q <= porBad_d;
      end
   end

   // chip select must be seen high before a new selection
   always @(posedge clk) begin
      if (rst)
         csHighSeen_q <= 1'b0;
      else if (state_d != `SFRS_ST_READY)
         csHighSeen_q <= csHighSeen_q & csNS;
      else
         csHighSeen_q <= csHighSeen_q | csNS;
   end

   // registered outputs
   always @(posedge clk) begin
      if (rst) begin
         ready_q      <= 1'b0;
         selected_q   <= 1'b0;
         sckRise_q    <= 1'b0;
         sckPrev_q    <= 1'b0;
         opAbort_q    <= 1'b0;
         regRestore_q <= 1'b0;
         ioOeN_q      <= 1'b1;
         porDone_q    <= 1'b0;
      end else begin
         ready_q      <= (state_d == `SFRS_ST_READY);
         selected_q   <= (state_d == `SFRS_ST_READY) && csHighSeen_q && !csNS;
         sckPrev_q    <= sckS;
         sckRise_q    <= (state_d == `SFRS_ST_READY) && csHighSeen_q && !csNS && sckS && !sckPrev_q;
         opAbort_q    <= abort_d;
         regRestore_q <= restore_d;
         // pins float unless ready and selected
         ioOeN_q      <= !((state_d == `SFRS_ST_READY) && csHighSeen_q && !csNS) | coreIoOeN;
         porDone_q    <= (state_d == `SFRS_ST_READY) || (state_d == `SFRS_ST_LOW)
                         || (state_d == `SFRS_ST_RECOV) || (state_d == `SFRS_ST_HELD);
      end
   end
endmodule

// >>> shared/sfrs_regs.vh
// Purpose: timing figures and state codes for the flash reset sequencer
// Assumes: 10 MHz system clock; figures are printed values in their own unit
// Notes:   cycle counts are derived from these in the sequencer itself
`ifndef SFRS_REGS_VH
`define SFRS_REGS_VH

// system clock rate in kHz
`define SFRS_CLK_KHZ            10000
// power-up delay, longest, in us
`define SFRS_POWERUP_DELAY_US   300
// hardware reset recovery, least, in us
`define SFRS_RECOVERY_TIME_US   35
// reset low pulse width, least, in ns
`define SFRS_PULSE_WIDTH_NS     200
// reset hold before chip select low, least, in ns
`define SFRS_HOLD_TIME_NS       50
// reset setup before a new reset, least, in ns
`define SFRS_SETUP_TIME_NS      50

// sequencer state codes
`define SFRS_ST_OFF    3'h0
`define SFRS_ST_POR    3'h1
`define SFRS_ST_HELD   3'h2
`define SFRS_ST_READY  3'h3
`define SFRS_ST_LOW    3'h4
`define SFRS_ST_RECOV  3'h5

`endif

// >>> hw/sfrs_sync.v
// Purpose: two-flop synchroniser for a group of asynchronous pins
// Assumes: each bit is an independent level
// Notes:   first stage is read by the second stage only
module sfrs_sync #(
   parameter WIDTH = 4,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input  wire             clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] pinIn,
   output wire [WIDTH-1:0] syncOut
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_q;
         reg stable_q;
         // two stages per pin
         always @(posedge clk) begin
            if (rst) begin
               meta_q   <= INIT[i];
               stable_q <= INIT[i];
            end else begin
               meta_q   <= pinIn[i];
               stable_q <= meta_q;
            end
         end
         assign syncOut[i] = stable_q;
      end
   endgenerate
endmodule

// >>> sim/sfrs_host.sv
// Purpose: host model for chip select, serial clock and reset pins
// Assumes: pins change on system clock falling edges
// Notes:   serial clock runs only inside frames
module sfrs_host (
   input  wire  clk,
   output logic csN,
   output logic sck,
   output logic resetN
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle: deselected, clock parked, reset high
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      resetN = 1'b1;
   end
   // chip select level
   task automatic cs(input logic lvl);
      @(negedge clk) csN = lvl;
   endtask
   // n serial clock periods of 800 ns
   task automatic clocks(input int n);
      repeat (n) begin
         repeat (4) @(negedge clk);
         sck = ~sck;
         repeat (4) @(negedge clk);
         sck = ~sck;
      end
   endtask
   // reset low for w cycles
   task automatic pulse(input int w);
      logic lvl;
      lvl = 1'b0;
      @(negedge clk) resetN = lvl;
      repeat (w) @(negedge clk);
      resetN = ~lvl;
   endtask
endmodule

// >>> sim/sfrs_properties.sv
// Purpose: port checks for the reset sequencer
// Assumes: one clock domain, sync active-high reset
// Notes:   cnt_q times delays from the last restore pulse
module sfrs_properties (
   input wire clk,
   input wire rst,
   input wire supplyOk,
   input wire porFault,
   input wire resetN,
   input wire csN,
   input wire sck,
   input wire coreIoOeN,
   input wire ready_q,
   input wire selected_q,
   input wire sckRise_q,
   input wire opAbort_q,
   input wire regRestore_q,
   input wire ioOeN_q,
   input wire porDone_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [12:0] cnt_d;
   logic [12:0] cnt_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // saturating count since restore
   always_comb cnt_d = regRestore_q ? 13'h0000 : cnt_q + {12'h000, ~&cnt_q};
   always_ff @(posedge clk) cnt_q <= rst ? 13'h0000 : cnt_d;
   a_ready_needs_por: assert property (ready_q |-> porDone_q) else $error("ready early");
   a_por_delay:
      assert property ($rose(porDone_q) |-> cnt_q >= 13'h0BAE && cnt_q <= 13'h0BBD) else $error("power-up delay");
   a_recovery_min: assert property ($rose(ready_q) |-> cnt_q >= 13'h0159) else $error("recovery short");
   a_idle_tristate: assert property (!ready_q |-> ioOeN_q) else $error("pins driven");
   a_sel_ready: assert property (selected_q |-> ready_q) else $error("selected early");
   a_sck_selected:
      assert property (sckRise_q |-> selected_q || $past(selected_q)) else $error("edge unselected");
   a_abort_pulse: assert property (opAbort_q |=> !opAbort_q) else $error("abort long");
   a_abort_restore:
      assert property (opAbort_q && supplyOk |-> regRestore_q && ioOeN_q && !ready_q) else $error("abort side");
   a_por_no_abort:
      assert property (!porDone_q && !$past(porDone_q) && supplyOk |-> !opAbort_q) else $error("reset in power-up");
   a_sck_from_pin:
      assert property (sckRise_q |-> $past(sck, 3) && !$past(sck, 4)) else $error("edge without pin edge");
   a_sel_cs_low: assert property (selected_q |-> !$past(csN, 3)) else $error("selected while deselected");
   a_oe_core: assert property (selected_q |-> ioOeN_q == $past(coreIoOeN)) else $error("oe not core");
   a_ready_reset_high: assert property ($rose(ready_q) |-> $past(resetN, 3)) else $error("ready under reset");
endmodule
bind sfrs_sequencer sfrs_properties u_props (.clk(clk), .rst(rst), .supplyOk(supplyOk), .porFault(porFault),
   .resetN(resetN), .csN(csN), .sck(sck), .coreIoOeN(coreIoOeN), .ready_q(ready_q), .selected_q(selected_q),
   .sckRise_q(sckRise_q), .opAbort_q(opAbort_q), .regRestore_q(regRestore_q), .ioOeN_q(ioOeN_q),
   .porDone_q(porDone_q));

// >>> sim/sfrs_sequencer_test.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: host model drives link pins
// Notes:   frames from a row table, resets by hand
module sfrs_sequencer_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       supplyOk = 1'b0;
   logic       porFault = 1'b0;
   logic       coreIoOeN = 1'b1;
   wire        csN, sck, resetN, ready_q, selected_q, sckRise_q, opAbort_q, regRestore_q, ioOeN_q, porDone_q;
   int         error_cnt = 0;
   int         tests_run = 0;
   int         cycles = 0;
   int         rises = 0;
   int         aborts = 0;
   int         restores = 0;
   int         n;
   logic [7:0] rows [3] = '{8'h01, 8'h13, 8'h08};
   sfrs_sequencer u_dut (.clk(clk), .rst(rst), .supplyOk(supplyOk), .porFault(porFault), .resetN(resetN),
      .csN(csN), .sck(sck), .coreIoOeN(coreIoOeN), .ready_q(ready_q), .selected_q(selected_q),
      .sckRise_q(sckRise_q), .opAbort_q(opAbort_q), .regRestore_q(regRestore_q), .ioOeN_q(ioOeN_q),
      .porDone_q(porDone_q));
   sfrs_host u_host (.clk(clk), .csN(csN), .sck(sck), .resetN(resetN));
   initial forever #50 clk = ~clk;
   // cycle ceiling and edge count
   always @(posedge clk) begin
      cycles++;
      if (sckRise_q === 1'b1) rises++;
      if (opAbort_q === 1'b1) aborts++;
      if (regRestore_q === 1'b1) restores++;
      if (cycles == 32'h4E20) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic exp, input logic seen);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %b seen %b", nm, exp, seen);
      end
   endtask
   // supply monitor and fault pins
   task automatic power(input logic ok, input logic flt);
      supplyOk = ok;
      porFault = flt;
   endtask
   task automatic inRange(input string nm, input int c, input int lo, input int hi);
      chk(nm, 1'b1, c >= lo && c <= hi);
   endtask
   task automatic waitReady(output int c);
      c = 0;
      while (ready_q !== 1'b1 && c < 4000) begin
         @(negedge clk);
         c++;
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      chk("reset oe", 1'b1, ioOeN_q);
      chk("reset ready", 1'b0, ready_q);
      power(1'b1, 1'b1);
      u_host.pulse(20);
      power(1'b1, 1'b0);
      waitReady(n);
      inRange("power-up", n + 21, 32'h0BB6, 32'h0BC0);
      foreach (rows[i]) begin
         coreIoOeN = rows[i][4];
         rises = 0;
         u_host.cs(1'b0);
         u_host.clocks(rows[i][3:0]);
         chk("selected", 1'b1, selected_q);
         chk("oe", rows[i][4], ioOeN_q);
         chk("rises", 1'b1, rises == rows[i][3:0]);
         u_host.cs(1'b1);
      end
      u_host.pulse(3);
      waitReady(n);
      inRange("full rerun", n, 32'h0BA0, 32'h0BC0);
      coreIoOeN = 1'b0;
      u_host.cs(1'b0);
      repeat (5) @(negedge clk);
      chk("oe drive", 1'b0, ioOeN_q);
      aborts = 0;
      restores = 0;
      u_host.pulse(4);
      repeat (2) @(negedge clk);
      chk("ready drop", 1'b0, ready_q);
      chk("tri-state", 1'b1, ioOeN_q);
      chk("abort once", 1'b1, aborts == 1);
      chk("restore once", 1'b1, restores == 1);
      u_host.cs(1'b1);
      waitReady(n);
      inRange("recovery", n, 32'h0150, 32'h0164);
      aborts = 0;
      u_host.pulse(1);
      repeat (6) @(negedge clk);
      chk("short pulse", 1'b1, ready_q);
      chk("short abort", 1'b1, aborts == 0);
      power(1'b0, 1'b0);
      repeat (5) @(negedge clk);
      chk("supply loss", 1'b0, ready_q);
      chk("loss abort", 1'b1, aborts == 1);
      power(1'b1, 1'b0);
      repeat (2900) @(negedge clk);
      u_host.pulse(200);
      chk("held", 1'b0, ready_q);
      chk("held done", 1'b1, porDone_q);
      waitReady(n);
      inRange("hold release", n, 32'h0000, 32'h0006);
      // reset again in mid-run
      rst = 1'b1;
      repeat (3) @(negedge clk);
      chk("mid reset ready", 1'b0, ready_q);
      chk("mid reset oe", 1'b1, ioOeN_q);
      chk("mid reset done", 1'b0, porDone_q);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      chk("mid release", 1'b0, ready_q);
      end_sim();
   end
endmodule
